/* File: rtl/pstr_defines.svh */
// Offsets, field positions, reset values and constants of the slot and phy tuning register bank.
// Included by the package and the bank; definitions only.
`ifndef PSTR_DEFINES_SVH
`define PSTR_DEFINES_SVH

// Byte addresses on the register bus
`define PSTR_OFS_LINK_CTRL   8'hc0
`define PSTR_OFS_SLOT_CAP    8'hc4
`define PSTR_OFS_SLOT_CTRL   8'hc8
`define PSTR_OFS_TUNE0       8'hcc
`define PSTR_OFS_TUNE1       8'hd0
`define PSTR_OFS_TUNE2       8'hd4
`define PSTR_OFS_IRQ_STATUS  8'he8
`define PSTR_OFS_IRQ_MASK    8'hec

// Slot capability bits that follow the hot-plug strap
`define PSTR_CAP_HP_MASK     32'h0000005d
// Edges to wait after reset before the synchronised strap is valid
`define PSTR_STRAP_WAIT      2'h2

// Slot control / status layout
`define PSTR_SCTL_RW_MASK    16'h07ff
`define PSTR_SSTS_EVT_LSB    16
`define PSTR_SSTS_EVT_W      5
`define PSTR_SSTS_LATCH_BIT  21
`define PSTR_SSTS_PRES_BIT   22

// Writable bits and reset values of the tuning registers
`define PSTR_TUNE0_RW_MASK   32'hffff1fff
`define PSTR_TUNE0_RESET     32'h04001060
`define PSTR_TUNE1_RW_MASK   32'hffff03ff
`define PSTR_TUNE1_RESET     32'h00000000
`define PSTR_TUNE2_RW_MASK   32'h007f7fff
`define PSTR_TUNE2_RESET     32'h00190254
`define PSTR_LINK_CTRL_MASK  32'h00000003
`define PSTR_LINK_CTRL_RESET 32'h00000000

// Fast training sequence ordered set: one comma then three K28.1
`define PSTR_FTS_COMMA       8'hbc
`define PSTR_FTS_FILL        8'h3c
`define PSTR_FTS_FILL_COUNT  3

// Interrupt status width (one bit per slot event)
`define PSTR_IRQ_W           5

`endif

/* File: rtl/pstr_pkg.sv */
// Types shared by the slot and phy tuning register bank.
// Assumes pstr_defines.svh is on the include path.
`include "pstr_defines.svh"

package pstr_pkg;

  // Slot events as raised by the hot-plug logic
  typedef struct packed {
    logic cmd_done;
    logic presence_chg;
    logic latch_chg;
    logic power_fault;
    logic button;
  } pstr_slot_evt_t;

  // Slot control outputs towards the hot-plug logic
  typedef struct packed {
    logic       power_ctl;
    logic [1:0] power_ind;
    logic [1:0] atten_ind;
    logic       hp_int_en;
    logic [4:0] evt_en;
  } pstr_slot_ctl_t;

  // Phy tuning values towards the link training logic
  typedef struct packed {
    logic [15:0] l1_entry_timer;
    logic [4:0]  ts1_count;
    logic [2:0]  lane_neg_tries;
    logic        debug_sel;
    logic        force_config;
    logic        cross_link_en;
    logic        loopback_en;
    logic        hot_reset_en;
    logic [15:0] l1_life_timer;
    logic [9:0]  l0s_life_timer;
    logic [7:0]  clock_recovery_fts;
    logic [6:0]  l0s_exit_lat;
    logic [6:0]  l1_exit_lat;
    logic [1:0]  active_link_power_saving;
  } pstr_tune_t;

endpackage

/* File: rtl/pstr_regs.sv */
// Slot capability/control/status and phy tuning register bank behind an Avalon-MM slave.
// Assumes strap and slot-state inputs arrive asynchronously; events are core_clk pulses.
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
`include "pstr_defines.svh"

// Notes on behaviour
// - Five slot capability bits read 1 only with hot-plug strap in reverse mode.
// - Power controller, surprise, power limit, scale and slot number read zero.
// - Slot control bits 4:0 are writable event enables, reset to zero.
// - Bits 5, 7:6, 9:8, 10 of slot control are writable, reset zero.
// - Slot status bits 16..22 are read-only flags, reset zero.
// - Tuning 0 bits 0..2 enable hot reset, loopback, cross-link; reset zero.
// - Tuning 0 bit 3 forces training to Configuration, bit 4 debug select.
// - Tuning 0 bits 7:5 hold lane negotiation attempts, reset 3.
// - Tuning 0 bits 31:16 hold L1 entry timer default, reset 0400h.
// - Tuning 1 holds L0s lifetime bits 9:0, L1 lifetime bits 31:16.
// - Tuning 2 bits 7:0 hold clock recovery time in FTS sets, reset 54h.
// - An FTS ordered set is one K28.5 comma then three K28.1.
// - Tuning 2 bits 14:8 hold L0s exit latency, reset 2.
// - Tuning 2 bits 22:16 hold L1 exit latency, reset 19h.
// - Two-bit link power control selects L0s, L1, both or none; resets off.
module pstr_regs
(
  input  wire logic                    core_clk,
  input  wire logic                    rstn,
  input  wire logic [7:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic [31:0]                  avs_readdata,
  output logic                         avs_waitrequest,
  input  wire logic                    hp_strap,
  input  wire logic                    reverse_mode,
  input  wire logic                    latch_state,
  input  wire logic                    presence_state,
  input  wire pstr_pkg::pstr_slot_evt_t slot_evt,
  output pstr_pkg::pstr_slot_ctl_t     slot_ctl,
  output pstr_pkg::pstr_tune_t         tune,
  output logic [8:0]                   fts_symbol,
  output logic                         irq
);

  // Two-flop synchronisers for the asynchronous levels
  logic [3:0] sync_a;
  logic [3:0] sync_b;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end
    else
    begin
      sync_a <= {presence_state, latch_state, reverse_mode, hp_strap};
      sync_b <= sync_a;
    end
  end

  // Strap captured once, after the synchroniser has filled; a later strap change is ignored
  logic       hp_cap;
  logic       strap_taken;
  logic [1:0] strap_wait;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hp_cap      <= 1'b0;
      strap_taken <= 1'b0;
      strap_wait  <= 2'h0;
    end
    else if (!strap_taken)
    begin
      if (strap_wait == `PSTR_STRAP_WAIT)
      begin
        hp_cap      <= sync_b[0] & sync_b[1];
        strap_taken <= 1'b1;
      end
      else
        strap_wait <= strap_wait + 2'h1;
    end
  end

  // Slot capability: only strap-dependent bits can be set, rest reads zero
  logic [31:0] slot_cap;
  assign slot_cap = hp_cap ? `PSTR_CAP_HP_MASK : 32'h0000_0000;

  // Bus handshake: every access gets one wait cycle, answer on the second edge
  logic acc_pending;
  logic acc_take;
  assign acc_take = (avs_read | avs_write) & acc_pending;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      acc_pending <= 1'b0;
    else if (acc_take)
      acc_pending <= 1'b0;
    else if (avs_read | avs_write)
      acc_pending <= 1'b1;
  end

  logic wr_go;
  logic rd_go;
  assign wr_go = acc_take & avs_write;
  assign rd_go = acc_take & avs_read;

  // Byte-lane write mask
  logic [31:0] be_mask;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_be
      assign be_mask[gi*8 +: 8] = {8{avs_byteenable[gi]}};
    end
  endgenerate

  // Masked write helper: only writable bits on enabled lanes change
  function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] wd,
                                        input logic [31:0] rw, input logic [31:0] be);
    logic [31:0] m;
    m = rw & be;
    merge = (cur & ~m) | (wd & m);
  endfunction

  // Writable registers
  logic [31:0] slot_ctrl_r;
  logic [31:0] tune0;
  logic [31:0] tune1;
  logic [31:0] tune2;
  logic [31:0] link_ctrl;
  logic [31:0] irq_mask;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      slot_ctrl_r <= 32'h0000_0000;
      tune0       <= `PSTR_TUNE0_RESET;
      tune1       <= `PSTR_TUNE1_RESET;
      tune2       <= `PSTR_TUNE2_RESET;
      link_ctrl   <= `PSTR_LINK_CTRL_RESET;
      irq_mask    <= 32'h0000_0000;
    end
    else if (wr_go)
    begin
      case (avs_address)
        `PSTR_OFS_SLOT_CTRL:
          slot_ctrl_r <= merge(slot_ctrl_r, avs_writedata, {16'h0000, `PSTR_SCTL_RW_MASK}, be_mask);
        `PSTR_OFS_TUNE0:
          tune0 <= merge(tune0, avs_writedata, `PSTR_TUNE0_RW_MASK, be_mask);
        `PSTR_OFS_TUNE1:
          tune1 <= merge(tune1, avs_writedata, `PSTR_TUNE1_RW_MASK, be_mask);
        `PSTR_OFS_TUNE2:
          tune2 <= merge(tune2, avs_writedata, `PSTR_TUNE2_RW_MASK, be_mask);
        `PSTR_OFS_LINK_CTRL:
          link_ctrl <= merge(link_ctrl, avs_writedata, `PSTR_LINK_CTRL_MASK, be_mask);
        `PSTR_OFS_IRQ_MASK:
          irq_mask <= merge(irq_mask, avs_writedata, 32'h0000_001f, be_mask);
        default:
          ;
      endcase
    end
  end

  // Slot status event flags: set by events, cleared by a slot status read; set wins.
  // Only the flags that the read reported are cleared, so an event in the wait cycle is kept.
  logic [4:0] evt_vec;
  logic [4:0] slot_flags;
  logic       rd_slot;
  assign evt_vec = slot_evt;
  assign rd_slot = rd_go & (avs_address == `PSTR_OFS_SLOT_CTRL);

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      slot_flags <= 5'h00;
    else
      slot_flags <= evt_vec | (rd_slot ? (slot_flags & ~avs_readdata[20:16]) : slot_flags);
  end

  // Interrupt status: sticky per event, read of status clears what it reported, set wins
  logic [4:0] irq_status;
  logic [4:0] next_irq_status;
  logic       rd_irq;
  assign rd_irq          = rd_go & (avs_address == `PSTR_OFS_IRQ_STATUS);
  assign next_irq_status = evt_vec | (rd_irq ? (irq_status & ~avs_readdata[4:0]) : irq_status);

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      irq_status <= 5'h00;
    else
      irq_status <= next_irq_status;
  end

  // Level interrupt from a flop; a mask bit of 1 lets its status bit through
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      irq <= 1'b0;
    else
      irq <= |(next_irq_status & irq_mask[4:0]);
  end

  // Read mux; unmapped addresses answer zero
  logic [31:0] slot_word;
  logic [31:0] rd_mux;
  assign slot_word = {9'h000, sync_b[3], sync_b[2], slot_flags, slot_ctrl_r[15:0]};

  always_comb
  begin
    case (avs_address)
      `PSTR_OFS_LINK_CTRL:  rd_mux = link_ctrl;
      `PSTR_OFS_SLOT_CAP:   rd_mux = slot_cap;
      `PSTR_OFS_SLOT_CTRL:  rd_mux = slot_word;
      `PSTR_OFS_TUNE0:      rd_mux = tune0;
      `PSTR_OFS_TUNE1:      rd_mux = tune1;
      `PSTR_OFS_TUNE2:      rd_mux = tune2;
      `PSTR_OFS_IRQ_STATUS: rd_mux = {27'h0000000, irq_status};
      `PSTR_OFS_IRQ_MASK:   rd_mux = irq_mask;
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data registered in the wait cycle so it stands at the accepting edge
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read & ~acc_pending)
      avs_readdata <= rd_mux;
  end

  // Waitrequest high except in the cycle where the access is accepted
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= ~((avs_read | avs_write) & ~acc_pending);
  end

  // Registered copies of control fields towards the link logic
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      slot_ctl <= '0;
      tune     <= '0;
    end
    else
    begin
      slot_ctl                      <= slot_ctrl_r[10:0];
      tune.hot_reset_en             <= tune0[0];
      tune.loopback_en              <= tune0[1];
      tune.cross_link_en            <= tune0[2];
      tune.force_config             <= tune0[3];
      tune.debug_sel                <= tune0[4];
      tune.lane_neg_tries           <= tune0[7:5];
      tune.ts1_count                <= tune0[12:8];
      tune.l1_entry_timer           <= tune0[31:16];
      tune.l0s_life_timer           <= tune1[9:0];
      tune.l1_life_timer            <= tune1[31:16];
      tune.clock_recovery_fts       <= tune2[7:0];
      tune.l0s_exit_lat             <= tune2[14:8];
      tune.l1_exit_lat              <= tune2[22:16];
      tune.active_link_power_saving <= link_ctrl[1:0];
    end
  end

  // FTS symbol stream: index 0 is the comma (K flag in bit 8), then three fill symbols
  logic [1:0] fts_idx;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      fts_idx    <= 2'h0;
      fts_symbol <= 9'h000;
    end
    else
    begin
      fts_idx    <= fts_idx + 2'h1;
      fts_symbol <= (fts_idx == 2'h0) ? {1'b1, `PSTR_FTS_COMMA} : {1'b1, `PSTR_FTS_FILL};
    end
  end

endmodule
`default_nettype wire

/* File: test/pcie_slot_and_phy_tuning_regs_bench.sv */
// Self-checking bench for the slot and phy tuning register bank.
// Assumes an interrupt mask bit of 1 lets its status bit raise the interrupt.
`timescale 1ns/100ps
`default_nettype none
module pcie_slot_and_phy_tuning_regs_bench;
  logic                     core_clk = 1'b0;
  logic                     rstn = 1'b0;
  logic [7:0]               avs_address = 8'h00;
  logic                     avs_read = 1'b0;
  logic                     avs_write = 1'b0;
  logic [31:0]              avs_writedata = 32'h0;
  logic [3:0]               avs_byteenable = 4'hf;
  logic [31:0]              avs_readdata;
  logic                     avs_waitrequest;
  logic                     hp_strap = 1'b0;
  logic                     reverse_mode = 1'b0;
  logic                     latch_state = 1'b0;
  logic                     presence_state = 1'b0;
  pstr_pkg::pstr_slot_evt_t slot_evt = '0;
  pstr_pkg::pstr_slot_ctl_t slot_ctl;
  pstr_pkg::pstr_tune_t     tune;
  logic [8:0]               fts_symbol;
  logic                     irq;
  int                       mismatches = 0;
  int                       check_count = 0;
  int                       cycles = 0;
  logic [31:0]              rdat;
  pstr_regs u_dut (.core_clk(core_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .hp_strap(hp_strap),
    .reverse_mode(reverse_mode), .latch_state(latch_state), .presence_state(presence_state),
    .slot_evt(slot_evt), .slot_ctl(slot_ctl), .tune(tune), .fts_symbol(fts_symbol), .irq(irq));
  // 250 MHz clock
  always #2 core_clk = ~core_clk;
  // Hang guard, far above the 155 or so cycles the tests need
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      mismatches++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // One bus transfer; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge core_clk);
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(rdat, exp);
  endtask
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic t_reset();
    rd_chk(8'hc0, 32'h0);
    rd_chk(8'hc4, 32'h0);
    rd_chk(8'hc8, 32'h0);
    rd_chk(8'hcc, 32'h04001060);
    rd_chk(8'hd0, 32'h0);
    rd_chk(8'hd4, 32'h00190254);
    rd_chk(8'h00, 32'h0);
    $display("test reset done");
  endtask
  // Ones then zeros on link, slot control and tuning registers: only writable bits may stick
  task automatic t_rw();
    logic [7:0]  a[5] = '{8'hc0, 8'hc8, 8'hcc, 8'hd0, 8'hd4};
    logic [31:0] m[5] = '{32'h3, 32'h7ff, 32'hffff1fff, 32'hffff03ff, 32'h007f7fff};
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b1, a[i], 32'hffffffff, 4'hf);
      rd_chk(a[i], m[i]);
      bus(1'b1, a[i], 32'h0, 4'hf);
      rd_chk(a[i], 32'h0);
    end
    bus(1'b1, 8'hc4, 32'hffffffff, 4'hf);
    rd_chk(8'hc4, 32'h0);
    bus(1'b1, 8'hcc, 32'ha5a5a5a5, 4'h2);
    rd_chk(8'hcc, 32'h00000500);
    chk({27'h0, tune.ts1_count}, 32'h5);
    bus(1'b1, 8'hc8, 32'h00000155, 4'hf);
    repeat (2) @(posedge core_clk);
    chk({21'h0, slot_ctl}, 32'h155);
    $display("test access done");
  endtask
  task automatic t_evt();
    latch_state <= 1'b1;
    bus(1'b1, 8'hec, 32'h1f, 4'hf);
    @(posedge core_clk);
    slot_evt <= 5'h01;
    @(posedge core_clk);
    slot_evt <= 5'h00;
    repeat (3) @(posedge core_clk);
    chk({31'h0, irq}, 32'h1);
    rd_chk(8'hc8, 32'h00210155);
    rd_chk(8'hc8, 32'h00200155);
    rd_chk(8'he8, 32'h1);
    repeat (3) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, 8'hec, 32'h0f, 4'hf);
    slot_evt <= 5'h10;
    @(posedge core_clk);
    slot_evt <= 5'h00;
    repeat (3) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    rd_chk(8'he8, 32'h10);
    $display("test events done");
  endtask
  // Strap needs both hot-plug and reverse mode, sampled after reset
  task automatic t_cap();
    hp_strap <= 1'b1;
    do_reset();
    rd_chk(8'hc4, 32'h0);
    reverse_mode <= 1'b1;
    do_reset();
    rd_chk(8'hc4, 32'h0000005d);
    rd_chk(8'hcc, 32'h04001060);
    $display("test capability done");
  endtask
  initial
  begin
    do_reset();
    t_reset();
    t_rw();
    t_evt();
    t_cap();
    summarize();
  end
endmodule
`default_nettype wire

/* File: test/pstr_regs_props.sv */
// Port-level assertions for the slot and phy tuning register bank.
// Assumes a bind onto pstr_regs and one-wait-cycle bus answers.
`timescale 1ns/100ps
`default_nettype none
module pstr_regs_props
(
  input wire logic                     core_clk,
  input wire logic                     rstn,
  input wire logic [7:0]               avs_address,
  input wire logic                     avs_read,
  input wire logic                     avs_write,
  input wire logic [31:0]              avs_writedata,
  input wire logic [3:0]               avs_byteenable,
  input wire logic [31:0]              avs_readdata,
  input wire logic                     avs_waitrequest,
  input wire pstr_pkg::pstr_slot_ctl_t slot_ctl,
  input wire pstr_pkg::pstr_tune_t     tune,
  input wire logic [8:0]               fts_symbol
);
  logic acc;
  logic full;
  // Accepted transfer; full-word write so every writable bit is known
  assign acc = !avs_waitrequest && (avs_read || avs_write);
  assign full = avs_write && acc && avs_byteenable == 4'hf;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_wait_bound: assert property ((avs_read || avs_write) |-> ##[0:2] !avs_waitrequest)
    else $error("request not answered");
  // Field outputs are copies of the registers, so a write shows two edges after acceptance
  a_ctl_write: assert property (full && avs_address == 8'hc8 |-> ##2 slot_ctl == $past(avs_writedata[10:0], 2))
    else $error("slot control write lost");
  a_ctl_hold: assert property (!(avs_write && acc && avs_address == 8'hc8) |-> ##2 $stable(slot_ctl))
    else $error("slot control changed without write");
  a_tune0_write: assert property (full && avs_address == 8'hcc |-> ##2 {tune.l1_entry_timer, 3'h0, tune.ts1_count,
    tune.lane_neg_tries, tune.debug_sel, tune.force_config, tune.cross_link_en, tune.loopback_en,
    tune.hot_reset_en} == ($past(avs_writedata, 2) & 32'hffff1fff)) else $error("tuning 0 write lost");
  a_tune1_write: assert property (full && avs_address == 8'hd0 |-> ##2
    {tune.l1_life_timer, 6'h0, tune.l0s_life_timer} == ($past(avs_writedata, 2) & 32'hffff03ff))
    else $error("tuning 1 write lost");
  a_tune2_write: assert property (full && avs_address == 8'hd4 |-> ##2 {9'h0, tune.l1_exit_lat, 1'b0,
    tune.l0s_exit_lat, tune.clock_recovery_fts} == ($past(avs_writedata, 2) & 32'h007f7fff))
    else $error("tuning 2 write lost");
  a_fts_order: assert property (fts_symbol == 9'h1bc |=> (fts_symbol == 9'h13c) [*3] ##1 fts_symbol == 9'h1bc)
    else $error("fast training set out of order");
  a_cap_zero: assert property (avs_read && acc && avs_address == 8'hc4 |-> (avs_readdata & 32'hffffffa2) == 32'h0)
    else $error("slot capability fixed bits not zero");
  a_ssts_resv: assert property (avs_read && acc && avs_address == 8'hc8 |-> (avs_readdata & 32'hff80f800) == 32'h0)
    else $error("slot reserved bits not zero");
endmodule
bind pstr_regs pstr_regs_props u_props (.core_clk(core_clk), .rstn(rstn), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .slot_ctl(slot_ctl), .tune(tune),
  .fts_symbol(fts_symbol));
`default_nettype wire
